// ---- irq_flag_enable_ctrl.sv ----
// Interrupt enable and flag registers of a small controller, with a Wishbone slave,
// sticky summary status, mask and one level interrupt output.
// Assumes timers, PWM and touch scanners pulse their events on clk_i; the CPU pulses
// a vector acknowledge per source. External pins are asynchronous.
//
// Contract
// - Enable register bits 6,5,1,0 gate PWM group, PWM main, touch B, touch A.
// - PWM group period end sets flag bit 6; writing BFh clears it.
// - Main PWM period end sets flag bit 5; writing DFh clears it.
// - Touch B scan end sets flag bit 1; writing FDh clears it.
// - Touch A scan end sets flag bit 0; writing FEh clears it.
// - Timer one overflow sets control bit 7; vectoring clears it.
// - Timer zero overflow sets control bit 5; vectoring clears it.
// - Run bits 6 and 4 start or stop timers one and zero, reset 0.
// - Falling edge on external pin one sets bit 3; vectoring clears it.
// - Bit 2 selects low level (0) or falling edge (1) for pin one.
// - Falling edge on external pin zero sets bit 1; vectoring clears it.
// - Bit 0 selects low level (0) or falling edge (1) for pin zero.
`default_nettype none

module irq_flag_enable_ctrl
(
  input  wire  logic                     clk_i,
  input  wire  logic                     rst_i,
  input  wire  irq_flag_pkg::wb_req_type wb_i,
  output logic                    [31:0] wb_dat_o,
  output logic                           wb_ack_o,
  input  wire  irq_flag_pkg::event_type  event_i,
  input  wire  irq_flag_pkg::vec_ack_type vec_ack_i,
  input  wire  logic                     ext_irq_pin_zero_i,
  input  wire  logic                     ext_irq_pin_one_i,
  output logic                           timer_one_run_o,
  output logic                           timer_zero_run_o,
  output logic                     [7:0] irq_req_o,
  output logic                           irq_o
);
  import irq_flag_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Keep bits where keep is one, then let every set win
  function automatic logic [7:0] merge_flags(input logic [7:0] old,
                                             input logic [7:0] set,
                                             input logic [7:0] keep);
    merge_flags = (old & keep) | set;
  endfunction

  function automatic logic [7:0] read_reg(input logic [9:0] idx, input ctrl_state_type s);
    case (idx)
      IDX_AUX_EN:  read_reg = s.en;
      IDX_AUX_FLG: read_reg = s.flg;
      IDX_TMR_EXT: read_reg = s.tmrx;
      IDX_IRQ_STS: read_reg = s.sts;
      IDX_IRQ_MSK: read_reg = s.msk;
      default:     read_reg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  logic [1:0] pin_level;
  logic [1:0] pin_fall;

  pin_edge_sync u_pin_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   ({ext_irq_pin_one_i, ext_irq_pin_zero_i}),
    .level_o (pin_level),
    .fall_o  (pin_fall)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  ctrl_state_type st;
  ctrl_state_type next_st;
  logic           fire;
  logic           wr;
  logic [9:0]     idx;
  logic           en_wr;
  logic           flg_wr;
  logic           tc_wr;
  logic           sts_wr;
  logic           msk_wr;

  assign fire = wb_i.cyc && wb_i.stb;
  // Writes land on the edge where the master samples ack
  assign wr     = fire && st.ack && wb_i.we && wb_i.sel[0];
  assign idx    = wb_i.adr[11:2];
  assign en_wr  = wr && (idx == IDX_AUX_EN);
  assign flg_wr = wr && (idx == IDX_AUX_FLG);
  assign tc_wr  = wr && (idx == IDX_TMR_EXT);
  assign sts_wr = wr && (idx == IDX_IRQ_STS);
  assign msk_wr = wr && (idx == IDX_IRQ_MSK);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [7:0] aux_set;
  logic [7:0] aux_keep;
  logic [7:0] tc_set;
  logic [7:0] tc_clr;
  logic [7:0] tc_base;
  logic [7:0] src;
  logic [7:0] sts_keep;

  always_comb
  begin
    next_st  = st;
    aux_set  = 8'h00;
    tc_set   = 8'h00;
    tc_clr   = 8'h00;
    src      = 8'h00;

    next_st.ack = fire && !st.ack;
    if (fire && !st.ack)
    begin
      next_st.dat = {24'h00_0000, read_reg(idx, st)};
    end

    if (en_wr)
    begin
      next_st.en = wb_i.dat[7:0] & AUX_MASK;
    end

    aux_set[BIT_PWM_GROUP] = event_i.pwm_group_end;
    aux_set[BIT_PWM_MAIN]  = event_i.pwm_main_end;
    aux_set[BIT_TOUCH_B]   = event_i.touch_b_done;
    aux_set[BIT_TOUCH_A]   = event_i.touch_a_done;
    // Bits written as one keep their flag, so a clear never races a set
    aux_keep    = flg_wr ? (wb_i.dat[7:0] | ~AUX_MASK) : 8'hFF;
    next_st.flg = merge_flags(st.flg, aux_set, aux_keep) & AUX_MASK;

    tc_set[BIT_T1_OVF]    = event_i.t1_ovf;
    tc_set[BIT_T0_OVF]    = event_i.t0_ovf;
    tc_set[BIT_EXT1_FLAG] = pin_fall[1];
    tc_set[BIT_EXT0_FLAG] = pin_fall[0];
    tc_clr[BIT_T1_OVF]    = vec_ack_i.t1;
    tc_clr[BIT_T0_OVF]    = vec_ack_i.t0;
    tc_clr[BIT_EXT1_FLAG] = vec_ack_i.ext1;
    tc_clr[BIT_EXT0_FLAG] = vec_ack_i.ext0;
    // Software may write every bit; hardware sets still win
    tc_base      = tc_wr ? wb_i.dat[7:0] : st.tmrx;
    next_st.tmrx = merge_flags(tc_base, tc_set, ~tc_clr);

    src[SRC_TOUCH_A]   = event_i.touch_a_done;
    src[SRC_TOUCH_B]   = event_i.touch_b_done;
    src[SRC_PWM_MAIN]  = event_i.pwm_main_end;
    src[SRC_PWM_GROUP] = event_i.pwm_group_end;
    src[SRC_T0]        = event_i.t0_ovf;
    src[SRC_T1]        = event_i.t1_ovf;
    src[SRC_EXT0]      = pin_fall[0];
    src[SRC_EXT1]      = pin_fall[1];
    sts_keep    = sts_wr ? ~wb_i.dat[7:0] : 8'hFF;
    next_st.sts = merge_flags(st.sts, src, sts_keep);
    if (msk_wr)
    begin
      next_st.msk = wb_i.dat[7:0];
    end
    next_st.irq = |(next_st.sts & next_st.msk);

    next_st.req[SRC_TOUCH_A]   = next_st.flg[BIT_TOUCH_A] & next_st.en[BIT_TOUCH_A];
    next_st.req[SRC_TOUCH_B]   = next_st.flg[BIT_TOUCH_B] & next_st.en[BIT_TOUCH_B];
    next_st.req[SRC_PWM_MAIN]  = next_st.flg[BIT_PWM_MAIN] & next_st.en[BIT_PWM_MAIN];
    next_st.req[SRC_PWM_GROUP] = next_st.flg[BIT_PWM_GROUP] & next_st.en[BIT_PWM_GROUP];
    next_st.req[SRC_T0]        = next_st.tmrx[BIT_T0_OVF];
    next_st.req[SRC_T1]        = next_st.tmrx[BIT_T1_OVF];
    // Level mode asks while the pin is low; edge mode asks on the latched flag
    next_st.req[SRC_EXT0] = next_st.tmrx[BIT_EXT0_TRIG] ? next_st.tmrx[BIT_EXT0_FLAG]
                                                        : !pin_level[0];
    next_st.req[SRC_EXT1] = next_st.tmrx[BIT_EXT1_TRIG] ? next_st.tmrx[BIT_EXT1_FLAG]
                                                        : !pin_level[1];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= RST_CTRL;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_dat_o         = st.dat;
  assign wb_ack_o         = st.ack;
  assign timer_one_run_o  = st.tmrx[BIT_T1_RUN];
  assign timer_zero_run_o = st.tmrx[BIT_T0_RUN];
  assign irq_req_o        = st.req;
  assign irq_o            = st.irq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_enable_write_gates:
    assert property (en_wr |=> (st.en == ($past(wb_i.dat[7:0]) & AUX_MASK))
                     ##1 (!st.en[BIT_TOUCH_A] || !st.flg[BIT_TOUCH_A] || irq_req_o[SRC_TOUCH_A]))
      else $error("enable write not stored or not gating request");

  a_pwm_group_flag:
    assert property ((event_i.pwm_group_end |=> st.flg[BIT_PWM_GROUP])
                     and ((flg_wr && wb_i.dat[7:0] == CLR_PWM_GROUP && !event_i.pwm_group_end)
                          |=> !st.flg[BIT_PWM_GROUP]))
      else $error("pwm group flag set or clear wrong");

  a_pwm_main_flag:
    assert property ((event_i.pwm_main_end |=> st.flg[BIT_PWM_MAIN])
                     and ((flg_wr && wb_i.dat[7:0] == CLR_PWM_MAIN && !event_i.pwm_main_end)
                          |=> !st.flg[BIT_PWM_MAIN]))
      else $error("pwm main flag set or clear wrong");

  a_touch_b_flag:
    assert property ((event_i.touch_b_done |=> st.flg[BIT_TOUCH_B])
                     and ((flg_wr && wb_i.dat[7:0] == CLR_TOUCH_B && !event_i.touch_b_done)
                          |=> !st.flg[BIT_TOUCH_B]))
      else $error("touch b flag set or clear wrong");

  a_touch_a_flag:
    assert property ((event_i.touch_a_done |=> st.flg[BIT_TOUCH_A])
                     and ((flg_wr && wb_i.dat[7:0] == CLR_TOUCH_A && !event_i.touch_a_done)
                          |=> !st.flg[BIT_TOUCH_A]))
      else $error("touch a flag set or clear wrong");

  a_flag_write_keeps:
    assert property (flg_wr |=> ((st.flg & $past(wb_i.dat[7:0]) & AUX_MASK)
                                 == (($past(st.flg) & $past(wb_i.dat[7:0]) & AUX_MASK)
                                     | ($past(aux_set) & $past(wb_i.dat[7:0])))))
      else $error("flag write disturbed a bit written as one");

  a_timer_one_flag:
    assert property ((event_i.t1_ovf |=> st.tmrx[BIT_T1_OVF] ##1 irq_req_o[SRC_T1] || !st.tmrx[BIT_T1_OVF])
                     and ((vec_ack_i.t1 && !event_i.t1_ovf && !tc_wr) |=> !st.tmrx[BIT_T1_OVF]))
      else $error("timer one overflow flag wrong");

  a_timer_zero_flag:
    assert property ((event_i.t0_ovf |=> st.tmrx[BIT_T0_OVF])
                     and ((vec_ack_i.t0 && !event_i.t0_ovf && !tc_wr) |=> !st.tmrx[BIT_T0_OVF]))
      else $error("timer zero overflow flag wrong");

  a_timer_run_bits:
    assert property (tc_wr |=> timer_one_run_o == $past(wb_i.dat[BIT_T1_RUN])
                               && timer_zero_run_o == $past(wb_i.dat[BIT_T0_RUN]))
      else $error("run bits do not follow the control write");

  a_ext_one_flag:
    assert property ((pin_fall[1] |=> st.tmrx[BIT_EXT1_FLAG])
                     and ((vec_ack_i.ext1 && !pin_fall[1] && !tc_wr) |=> !st.tmrx[BIT_EXT1_FLAG]))
      else $error("external one flag wrong");

  a_ext_one_level:
    assert property ((!st.tmrx[BIT_EXT1_TRIG] && !tc_wr && !pin_level[1]) |=> irq_req_o[SRC_EXT1])
      else $error("external one level request missing");

  a_ext_zero_flag:
    assert property ((pin_fall[0] |=> st.tmrx[BIT_EXT0_FLAG])
                     and ((vec_ack_i.ext0 && !pin_fall[0] && !tc_wr) |=> !st.tmrx[BIT_EXT0_FLAG]))
      else $error("external zero flag wrong");

  a_ext_zero_mode:
    assert property ((st.tmrx[BIT_EXT0_TRIG] && !tc_wr && !st.tmrx[BIT_EXT0_FLAG] && !pin_fall[0]
                      && !vec_ack_i.ext0) |=> !irq_req_o[SRC_EXT0])
      else $error("external zero edge mode requests without a flag");

  a_ext_zero_level:
    assert property ((!st.tmrx[BIT_EXT0_TRIG] && !tc_wr && !pin_level[0]) |=> irq_req_o[SRC_EXT0])
      else $error("external zero level request missing");

  a_ext_one_mode:
    assert property ((st.tmrx[BIT_EXT1_TRIG] && !tc_wr && !st.tmrx[BIT_EXT1_FLAG] && !pin_fall[1]
                      && !vec_ack_i.ext1) |=> !irq_req_o[SRC_EXT1])
      else $error("external one edge mode requests without a flag");

  // Run bits move only through a control write, never as a side effect of flags
  a_run_bits_hold:
    assert property (!tc_wr |=> $stable(timer_one_run_o) && $stable(timer_zero_run_o))
      else $error("run bits changed without a control write");

  // Status bits are sticky until software writes a one to them
  a_status_sticky:
    assert property (!sts_wr |=> ((st.sts & $past(st.sts)) == $past(st.sts)))
      else $error("status bit lost without a clear");

  // Ack stands one cycle only; a request still held is acked again two cycles later
  a_ack_single_pulse:
    assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

endmodule // irq_flag_enable_ctrl

`default_nettype wire

// ---- irq_flag_pkg.sv ----
// Package for the interrupt enable and flag block: register indexes, field positions,
// reset values and the structs that carry bus, event and state bundles.
// Assumes a 32-bit classic Wishbone bus with byte addresses of four times the index.
`default_nettype none

package irq_flag_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indexes (byte address is four times the index)
  localparam logic [9:0] IDX_AUX_EN  = 10'h084;
  localparam logic [9:0] IDX_AUX_FLG = 10'h085;
  localparam logic [9:0] IDX_TMR_EXT = 10'h088;
  localparam logic [9:0] IDX_IRQ_STS = 10'h0F0;
  localparam logic [9:0] IDX_IRQ_MSK = 10'h0F1;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions of the enable and flag registers
  localparam int BIT_PWM_GROUP = 6;
  localparam int BIT_PWM_MAIN  = 5;
  localparam int BIT_TOUCH_B   = 1;
  localparam int BIT_TOUCH_A   = 0;
  localparam logic [7:0] AUX_MASK = 8'h63;

  // Documented clear patterns for the flag register
  localparam logic [7:0] CLR_PWM_GROUP = 8'hBF;
  localparam logic [7:0] CLR_PWM_MAIN  = 8'hDF;
  localparam logic [7:0] CLR_TOUCH_B   = 8'hFD;
  localparam logic [7:0] CLR_TOUCH_A   = 8'hFE;

  // Field positions of the timer and external interrupt control register
  localparam int BIT_T1_OVF    = 7;
  localparam int BIT_T1_RUN    = 6;
  localparam int BIT_T0_OVF    = 5;
  localparam int BIT_T0_RUN    = 4;
  localparam int BIT_EXT1_FLAG = 3;
  localparam int BIT_EXT1_TRIG = 2;
  localparam int BIT_EXT0_FLAG = 1;
  localparam int BIT_EXT0_TRIG = 0;

  // Source positions in the sticky status, mask and request vectors
  localparam int SRC_TOUCH_A   = 0;
  localparam int SRC_TOUCH_B   = 1;
  localparam int SRC_PWM_MAIN  = 2;
  localparam int SRC_PWM_GROUP = 3;
  localparam int SRC_T0        = 4;
  localparam int SRC_T1        = 5;
  localparam int SRC_EXT0      = 6;
  localparam int SRC_EXT1      = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_AUX_EN  = 8'h00;
  localparam logic [7:0] RST_AUX_FLG = 8'h00;
  localparam logic [7:0] RST_TMR_EXT = 8'h00;
  localparam logic [7:0] RST_IRQ_STS = 8'h00;
  localparam logic [7:0] RST_IRQ_MSK = 8'h00;
  localparam logic [1:0] RST_PIN     = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic pwm_group_end;
    logic pwm_main_end;
    logic touch_b_done;
    logic touch_a_done;
    logic t1_ovf;
    logic t0_ovf;
  } event_type;

  typedef struct packed {
    logic t1;
    logic t0;
    logic ext1;
    logic ext0;
  } vec_ack_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [7:0]  en;
    logic [7:0]  flg;
    logic [7:0]  tmrx;
    logic [7:0]  sts;
    logic [7:0]  msk;
    logic        irq;
    logic [7:0]  req;
  } ctrl_state_type;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
  } sync_state_type;

  localparam ctrl_state_type RST_CTRL = '{ack: 1'b0, dat: 32'h0000_0000, en: RST_AUX_EN,
                                          flg: RST_AUX_FLG, tmrx: RST_TMR_EXT, sts: RST_IRQ_STS,
                                          msk: RST_IRQ_MSK, irq: 1'b0, req: 8'h00};

endpackage

`default_nettype wire

// ---- pin_edge_sync.sv ----
// Two-stage synchroniser and falling edge detector for the two external interrupt pins.
// Assumes the pins are asynchronous to clk_i and idle high.
`default_nettype none

module pin_edge_sync
(
  input  wire  logic       clk_i,
  input  wire  logic       rst_i,
  input  wire  logic [1:0] pin_i,
  output logic       [1:0] level_o,
  output logic       [1:0] fall_o
);
  import irq_flag_pkg::*;

  sync_state_type st;
  sync_state_type next_st;

  // Stage s1 feeds s2 only; edges are seen between s2 and s3
  always_comb
  begin
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '{s1: RST_PIN, s2: RST_PIN, s3: RST_PIN};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level_o = st.s2;
  assign fall_o  = st.s3 & ~st.s2;

endmodule // pin_edge_sync

`default_nettype wire

// ---- cpu_bus_model.sv ----
// CPU side model: classic Wishbone master task and vector acknowledges.
// Assumes the block acks every request and holds its requests as levels.
`default_nettype none

module cpu_bus_model
(
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  output var  irq_flag_pkg::wb_req_type  wb_o,
  input  wire logic               [31:0] wb_dat_i,
  input  wire logic                      wb_ack_i,
  input  wire logic                [7:0] irq_req_i,
  input  wire logic                      auto_vec_i,
  output var  irq_flag_pkg::vec_ack_type vec_ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import irq_flag_pkg::*;

  initial
  begin
    wb_o = '0;
  end

  ////////////////////////////////////////
  // One vector per pending request; the block drops the level a cycle later
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vec_ack_o <= '0;
    end
    else
    begin
      vec_ack_o.t1 <= auto_vec_i & irq_req_i[SRC_T1] & ~vec_ack_o.t1;
      vec_ack_o.t0 <= auto_vec_i & irq_req_i[SRC_T0] & ~vec_ack_o.t0;
      vec_ack_o.ext1 <= auto_vec_i & irq_req_i[SRC_EXT1] & ~vec_ack_o.ext1;
      vec_ack_o.ext0 <= auto_vec_i & irq_req_i[SRC_EXT0] & ~vec_ack_o.ext0;
    end
  end

  ////////////////////////////////////////
  // Called right after a rising edge; waits for ack as long as it takes, the bench timeout ends a hang
  task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    wb_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1, dat: {24'h00_0000, wd}};
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1)
    begin
      @(posedge clk_i);
    end
    rd = wb_dat_i[7:0];
    // Released data lines do not keep the old value
    wb_o <= '{cyc: 1'b0, stb: 1'b0, we: wb_o.we, adr: wb_o.adr, sel: wb_o.sel, dat: ~wb_o.dat};
    @(posedge clk_i);
  endtask
endmodule // cpu_bus_model

`default_nettype wire

// ---- test_irq_flag_enable_ctrl.sv ----
// Self-checking bench for the interrupt enable and flag block.
// Assumes cpu_bus_model stands on the far side of the register bus.
`default_nettype none

module test_irq_flag_enable_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_flag_pkg::*;

  typedef struct packed {
    event_type  ev;
    logic [7:0] flag;
    logic [7:0] clr;
    logic [7:0] req;
  } row_type;

  logic        clk_i;
  logic        rst_i;
  wb_req_type  wb;
  logic [31:0] wb_dat;
  logic        wb_ack;
  event_type   ev;
  vec_ack_type vec;
  logic [1:0]  pins;
  logic        t1_run;
  logic        t0_run;
  logic [7:0]  irq_req;
  logic        irq;
  logic        auto_vec;
  int          mismatches;
  int          samples_checked;
  int          cycles;
  row_type     rows [4];

  irq_flag_enable_ctrl u_dut
  (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .wb_i              (wb),
    .wb_dat_o          (wb_dat),
    .wb_ack_o          (wb_ack),
    .event_i           (ev),
    .vec_ack_i         (vec),
    .ext_irq_pin_zero_i(pins[0]),
    .ext_irq_pin_one_i (pins[1]),
    .timer_one_run_o   (t1_run),
    .timer_zero_run_o  (t0_run),
    .irq_req_o         (irq_req),
    .irq_o             (irq)
  );

  cpu_bus_model u_cpu
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_o      (wb),
    .wb_dat_i  (wb_dat),
    .wb_ack_i  (wb_ack),
    .irq_req_i (irq_req),
    .auto_vec_i(auto_vec),
    .vec_ack_o (vec)
  );

  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_chk(input string what, input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    u_cpu.xfer(1'b0, idx, 8'h00, d);
    check(what, d, exp);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    u_cpu.xfer(1'b1, idx, d, unused);
  endtask

  task automatic pulse(input event_type e);
    ev <= e;
    @(posedge clk_i);
    ev <= '0;
    @(posedge clk_i);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // About 300 cycles of work; a hang is cut well after that
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      stop_test();
    end
  end

  initial
  begin
    rst_i = 1'b1;
    ev = '0;
    pins = 2'b11;
    auto_vec = 1'b0;
    rows[0] = '{6'h20, 8'h40, CLR_PWM_GROUP, 8'h08};
    rows[1] = '{6'h10, 8'h20, CLR_PWM_MAIN, 8'h04};
    rows[2] = '{6'h08, 8'h02, CLR_TOUCH_B, 8'h02};
    rows[3] = '{6'h04, 8'h01, CLR_TOUCH_A, 8'h01};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk("enable", IDX_AUX_EN, RST_AUX_EN);
    rd_chk("flags", IDX_AUX_FLG, RST_AUX_FLG);
    rd_chk("control", IDX_TMR_EXT, RST_TMR_EXT);
    rd_chk("status", IDX_IRQ_STS, RST_IRQ_STS);
    rd_chk("mask", IDX_IRQ_MSK, RST_IRQ_MSK);
    $display("test reset done");
    wr(IDX_AUX_EN, 8'hFF);
    rd_chk("enable bits", IDX_AUX_EN, AUX_MASK);
    for (int i = 0; i < 4; i++)
    begin
      pulse(rows[i].ev);
      rd_chk("flag set", IDX_AUX_FLG, rows[i].flag);
      check("request", irq_req, rows[i].req);
      rd_chk("status set", IDX_IRQ_STS, rows[i].req);
      wr(IDX_AUX_FLG, rows[i].clr);
      rd_chk("flag clear", IDX_AUX_FLG, 8'h00);
      wr(IDX_IRQ_STS, 8'hFF);
    end
    $display("test event rows done");
    ////////////////////////////////////////
    wr(IDX_AUX_EN, 8'h00);
    pulse(6'h3C);
    check("disabled", irq_req, 8'h00);
    wr(IDX_AUX_FLG, 8'hBE);
    rd_chk("partial", IDX_AUX_FLG, 8'h22);
    wr(IDX_AUX_FLG, 8'hFF);
    rd_chk("ones keep", IDX_AUX_FLG, 8'h22);
    $display("test enable gating done");
    for (int i = 0; i < 2; i++)
    begin
      pulse(i ? 6'h02 : 6'h01);
      rd_chk("timer flag", IDX_TMR_EXT, i ? 8'h80 : 8'h20);
      check("timer req", irq_req, i ? 8'h20 : 8'h10);
      auto_vec <= 1'b1;
      repeat (4) @(posedge clk_i);
      auto_vec <= 1'b0;
      rd_chk("timer vectored", IDX_TMR_EXT, 8'h00);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(IDX_TMR_EXT, {1'b0, i[1], 1'b0, i[0], 4'h0});
      rd_chk("run bits", IDX_TMR_EXT, {1'b0, i[1], 1'b0, i[0], 4'h0});
      check("run out", {6'h00, t1_run, t0_run}, i[1:0]);
    end
    $display("test timers done");
    for (int i = 0; i < 2; i++)
    begin
      wr(IDX_TMR_EXT, 8'h00);
      pins[i] <= 1'b0;
      repeat (6) @(posedge clk_i);
      check("level low", {7'h00, irq_req[6 + i]}, 8'h01);
      pins[i] <= 1'b1;
      repeat (6) @(posedge clk_i);
      check("level high", {7'h00, irq_req[6 + i]}, 8'h00);
      wr(IDX_TMR_EXT, i ? 8'h04 : 8'h01);
      pins[i] <= 1'b0;
      repeat (6) @(posedge clk_i);
      pins[i] <= 1'b1;
      repeat (6) @(posedge clk_i);
      check("edge req", {7'h00, irq_req[6 + i]}, 8'h01);
      rd_chk("edge flag", IDX_TMR_EXT, i ? 8'h0C : 8'h03);
      auto_vec <= 1'b1;
      repeat (4) @(posedge clk_i);
      auto_vec <= 1'b0;
      rd_chk("edge vectored", IDX_TMR_EXT, i ? 8'h04 : 8'h01);
      check("edge req off", {7'h00, irq_req[6 + i]}, 8'h00);
    end
    $display("test pins done");
    ////////////////////////////////////////
    wr(IDX_IRQ_STS, 8'hFF);
    wr(IDX_IRQ_MSK, 8'h01);
    pulse(6'h08);
    check("masked", {7'h00, irq}, 8'h00);
    pulse(6'h04);
    check("unmasked", {7'h00, irq}, 8'h01);
    wr(IDX_IRQ_STS, 8'h01);
    rd_chk("w1c", IDX_IRQ_STS, 8'h02);
    check("irq cleared", {7'h00, irq}, 8'h00);
    wr(10'h086, 8'hFF);
    rd_chk("unmapped", 10'h086, 8'h00);
    $display("test status done");
    wr(IDX_AUX_EN, 8'h63);
    wr(IDX_TMR_EXT, 8'h50);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("run reset", {6'h00, t1_run, t0_run}, 8'h00);
    rd_chk("enable reset", IDX_AUX_EN, 8'h00);
    $display("test second reset done");
    stop_test();
  end
endmodule // test_irq_flag_enable_ctrl

`default_nettype wire
